// ===== design/gtm_mem.sv
// flash array and general ram, registered read ports
`timescale 1ns/1ns
module gtm_mem (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  gtm_mem_if.mem bus
);
  import gtm_pkg::*;
  logic [7:0] flash_arr [0:95];
  logic [7:0] ram_arr [0:RAM_BYTES-1];
  logic [7:0] fl_rdata_reg;
  logic [7:0] ram_rdata_reg;
  logic [7:0] fl_rdata_next;
  logic [7:0] ram_rdata_next;

  // out-of-range flash address reads as erased
  always_comb begin
    fl_rdata_next = (bus.fl_addr < FLASH_BYTES) ? flash_arr[bus.fl_addr] : ERASED_BYTE;
    ram_rdata_next = ram_arr[bus.ram_addr];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fl_rdata_reg <= ZERO_BYTE;
      ram_rdata_reg <= ZERO_BYTE;
    end else begin
      fl_rdata_reg <= fl_rdata_next;
      ram_rdata_reg <= ram_rdata_next;
    end
  end

  // storage itself has no reset: flash keeps its contents
  always_ff @(posedge sys_clk_i) begin
    if (bus.fl_we && (bus.fl_addr < FLASH_BYTES)) begin
      flash_arr[bus.fl_addr] <= bus.fl_wdata;
    end
    if (bus.ram_we) begin
      ram_arr[bus.ram_addr] <= bus.ram_wdata;
    end
  end

  assign bus.fl_rdata = fl_rdata_reg;
  assign bus.ram_rdata = ram_rdata_reg;
endmodule

// ===== design/gtm_mem_if.sv
// bundle between the register logic and the flash and ram storage
`timescale 1ns/1ns
interface gtm_mem_if;
  logic [6:0] fl_addr;
  logic fl_we;
  logic [7:0] fl_wdata;
  logic [7:0] fl_rdata;
  logic [4:0] ram_addr;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  modport ctl (output fl_addr, fl_we, fl_wdata, ram_addr, ram_we, ram_wdata,
    input fl_rdata, ram_rdata);
  modport mem (input fl_addr, fl_we, fl_wdata, ram_addr, ram_we, ram_wdata,
    output fl_rdata, ram_rdata);
endinterface

// ===== design/gtm_pkg.sv
// shared constants and types for the time, mode, clear and flash command registers
package gtm_pkg;
  localparam int REG_ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] ADDR_FLASH_COMMAND = 7'h62;
  localparam logic [6:0] ADDR_COUNTER_CLEAR = 7'h63;
  localparam logic [6:0] ADDR_MODE_CONTROL = 7'h64;
  localparam logic [6:0] ADDR_CHARGE_TIME_LOW = 7'h65;
  localparam logic [6:0] ADDR_CHARGE_TIME_HIGH = 7'h66;
  localparam logic [6:0] ADDR_DISCHARGE_TIME_LOW = 7'h67;
  localparam logic [6:0] ADDR_DISCHARGE_TIME_HIGH = 7'h68;
  localparam logic [6:0] ADDR_PROGRAM_DATA = 7'h6F;
  localparam logic [6:0] ADDR_PROGRAM_ADDRESS = 7'h70;
  localparam logic [6:0] FLASH_BYTES = 7'h60;
  localparam int RAM_BYTES = 32;
  localparam int PAGE_IDX_W = 5;
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // mode_control fields
  localparam int MODE_DIR_BIT = 7;
  localparam int MODE_LEVEL_BIT = 6;
  localparam int MODE_SLOW_CHG_BIT = 5;
  localparam int MODE_SLOW_DIS_BIT = 4;
  localparam int MODE_WAKE_MSB = 3;
  localparam int MODE_WAKE_LSB = 1;
  localparam int MODE_POR_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h4F;
  // counter_clear fields
  localparam int CLR_CHARGE_TIME_BIT = 4;
  localparam int CLR_DISCHARGE_TIME_BIT = 3;
  localparam int CLR_SELF_DISCHARGE_BIT = 2;
  localparam int CLR_CHARGE_COUNT_BIT = 1;
  localparam int CLR_DISCHARGE_COUNT_BIT = 0;
  localparam logic [4:0] CLEAR_RESET = 5'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // flash command codes
  localparam logic [7:0] CMD_PROGRAM_BYTE = 8'h0F;
  localparam logic [7:0] CMD_ERASE_PAGE0 = 8'h40;
  localparam logic [7:0] CMD_ERASE_PAGE1 = 8'h41;
  localparam logic [7:0] CMD_ERASE_PAGE2 = 8'h42;
  localparam logic [7:0] CMD_RAM_TO_FLASH = 8'h45;
  localparam logic [7:0] CMD_FLASH_TO_RAM = 8'h48;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hF6;
  // timebase
  localparam longint CLK_HZ = 25_000_000;
  localparam longint HOUR_S = 3600;
  localparam longint FAST_COUNTS_PER_HOUR = 4096;
  localparam longint SLOW_COUNTS_PER_HOUR = 16;
  localparam longint FAST_DIV_CYC = CLK_HZ * HOUR_S / FAST_COUNTS_PER_HOUR;
  localparam longint SLOW_DIV_CYC = CLK_HZ * HOUR_S / SLOW_COUNTS_PER_HOUR;
  localparam int PRESCALE_W = 33;
  localparam int CH_CHARGE = 0;
  localparam int CH_DISCHARGE = 1;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_SLEEP_WAIT = 3'b011,
    ST_SLEEP = 3'b100,
    ST_DONE = 3'b101
  } gtm_state_t;
  typedef enum logic [1:0] {
    OP_ERASE = 2'b00,
    OP_PROGRAM = 2'b01,
    OP_RAM_TO_FLASH = 2'b10,
    OP_FLASH_TO_RAM = 2'b11
  } gtm_op_t;
endpackage

// ===== design/gtm_regs.sv
// time accumulators, mode, clear and flash command registers of the battery monitor
`timescale 1ns/1ns
module gtm_regs #(
  parameter longint FAST_DIV = gtm_pkg::FAST_DIV_CYC,
  parameter longint SLOW_DIV = gtm_pkg::SLOW_DIV_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [gtm_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [gtm_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [gtm_pkg::DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic discharge_i,
  input wire logic charge_i,
  input wire logic [2:0] sense_level_i,
  input wire logic supply_low_i,
  input wire logic single_wire_pin_i,
  input wire logic gpio_in_i,
  output logic gpio_out_o,
  output logic gpio_oe_n_o,
  output logic [2:0] count_clear_o,
  output logic sleep_o,
  output logic busy_o
);
  import gtm_pkg::*;

  gtm_mem_if mem_bus ();

  gtm_mem u_mem (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .bus(mem_bus.mem)
  );

  // synchronisers for everything arriving from pins or analog comparators
  localparam int SYNC_W = 8;
  // serial pin idles high: reset to that level so no false wake edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_RESET = 8'h04;
  logic [SYNC_W-1:0] sync1_reg, sync1_next;
  logic [SYNC_W-1:0] sync2_reg, sync2_next;
  logic wire_d_reg, wire_d_next;
  logic dis_s, chg_s, supply_low_s, wire_s, gpio_s;
  logic [2:0] level_s;

  always_comb begin
    sync1_next = {gpio_in_i, sense_level_i, supply_low_i, single_wire_pin_i, charge_i,
      discharge_i};
    sync2_next = sync1_reg;
    wire_d_next = sync2_reg[2];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
      wire_d_reg <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      wire_d_reg <= wire_d_next;
    end
  end

  assign dis_s = sync2_reg[0];
  assign chg_s = sync2_reg[1];
  assign wire_s = sync2_reg[2];
  assign supply_low_s = sync2_reg[3];
  assign level_s = sync2_reg[6:4];
  assign gpio_s = sync2_reg[7];

  // host register file
  logic [7:0] mode_reg, mode_next;
  logic [4:0] clear_reg, clear_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] prog_addr_reg, prog_addr_next;
  logic [7:0] prog_data_reg, prog_data_next;
  logic [15:0] time_cnt [0:1];
  logic slow_flag [0:1];
  gtm_state_t state_reg, state_next;
  logic cmd_done;

  always_comb begin
    mode_next = mode_reg;
    clear_next = CLEAR_RESET;
    prog_addr_next = prog_addr_reg;
    prog_data_next = prog_data_reg;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_MODE_CONTROL: mode_next = reg_wdata_i;
        ADDR_COUNTER_CLEAR: clear_next = reg_wdata_i[4:0];
        ADDR_PROGRAM_ADDRESS: prog_addr_next = reg_wdata_i;
        ADDR_PROGRAM_DATA: prog_data_next = reg_wdata_i;
        default: ;
      endcase
    end
    // supply drop wins over a host clear in the same cycle
    if (supply_low_s) begin
      mode_next[MODE_POR_BIT] = 1'b1;
    end
    // slow flags live in the accumulators, the stored copies are unused
    mode_next[MODE_SLOW_CHG_BIT] = 1'b0;
    mode_next[MODE_SLOW_DIS_BIT] = 1'b0;
  end

  // command register: accepted only while idle and empty
  always_comb begin
    cmd_next = cmd_reg;
    if (cmd_done) begin
      cmd_next = ZERO_BYTE;
    end else if (reg_wr_i && reg_addr_i == ADDR_FLASH_COMMAND && state_reg == ST_IDLE &&
        cmd_reg == ZERO_BYTE) begin
      cmd_next = reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_reg <= MODE_RESET;
      clear_reg <= CLEAR_RESET;
      cmd_reg <= ZERO_BYTE;
      prog_addr_reg <= ZERO_BYTE;
      prog_data_reg <= ZERO_BYTE;
    end else begin
      mode_reg <= mode_next;
      clear_reg <= clear_next;
      cmd_reg <= cmd_next;
      prog_addr_reg <= prog_addr_next;
      prog_data_reg <= prog_data_next;
    end
  end

  // the external counter pairs are cleared by the pulse the clear bit makes
  assign count_clear_o = clear_reg[2:0];

  // time accumulators, one per direction
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_time
      logic [15:0] cnt_reg, cnt_next;
      logic slow_reg, slow_next;
      logic [PRESCALE_W-1:0] pre_reg, pre_next;
      logic active, clr, tick;

      assign active = (ch == CH_CHARGE) ? chg_s : dis_s;
      assign clr = (ch == CH_CHARGE) ? clear_reg[CLR_CHARGE_TIME_BIT]
                                     : clear_reg[CLR_DISCHARGE_TIME_BIT];
      // rate drops from 4096 to 16 per hour while the slow flag is up
      assign tick = active && (pre_reg == (slow_reg ? PRESCALE_W'(SLOW_DIV - 1)
                                                    : PRESCALE_W'(FAST_DIV - 1)));

      always_comb begin
        cnt_next = cnt_reg;
        slow_next = slow_reg;
        pre_next = pre_reg;
        if (active) begin
          pre_next = tick ? '0 : pre_reg + 1'b1;
        end
        if (clr) begin
          cnt_next = 16'h0000;
          slow_next = 1'b0;
          pre_next = '0;
        end
        if (tick) begin
          cnt_next = clr ? 16'h0000 : cnt_reg + 16'h0001;
          // a rollover toggles: first sets, second clears; beats a clear
          if (cnt_reg == 16'hFFFF) begin
            slow_next = ~slow_reg;
          end
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          cnt_reg <= 16'h0000;
          slow_reg <= 1'b0;
          pre_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
          slow_reg <= slow_next;
          pre_reg <= pre_next;
        end
      end

      assign time_cnt[ch] = cnt_reg;
      assign slow_flag[ch] = slow_reg;
    end
  endgenerate

  // flash command sequencer
  gtm_op_t op_reg, op_next;
  logic [4:0] idx_reg, idx_next;
  logic [1:0] page_reg, page_next;
  logic [2:0] wake_thr;
  logic wire_edge;

  assign wake_thr = mode_reg[MODE_WAKE_MSB:MODE_WAKE_LSB];
  assign wire_edge = wire_s ^ wire_d_reg;
  assign cmd_done = (state_reg == ST_DONE) || (state_reg == ST_IDLE && cmd_reg != ZERO_BYTE &&
    cmd_reg != CMD_PROGRAM_BYTE && cmd_reg != CMD_ERASE_PAGE0 && cmd_reg != CMD_ERASE_PAGE1 &&
    cmd_reg != CMD_ERASE_PAGE2 && cmd_reg != CMD_RAM_TO_FLASH && cmd_reg != CMD_FLASH_TO_RAM &&
    cmd_reg != CMD_POWER_DOWN);

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    idx_next = idx_reg;
    page_next = page_reg;
    unique case (state_reg)
      ST_IDLE: begin
        idx_next = 5'h00;
        page_next = 2'b00;
        state_next = ST_READ;
        unique case (cmd_reg)
          CMD_PROGRAM_BYTE: op_next = OP_PROGRAM;
          CMD_ERASE_PAGE0: op_next = OP_ERASE;
          CMD_ERASE_PAGE1: begin
            op_next = OP_ERASE;
            page_next = 2'b01;
          end
          CMD_ERASE_PAGE2: begin
            op_next = OP_ERASE;
            page_next = 2'b10;
          end
          CMD_RAM_TO_FLASH: op_next = OP_RAM_TO_FLASH;
          CMD_FLASH_TO_RAM: op_next = OP_FLASH_TO_RAM;
          CMD_POWER_DOWN: state_next = ST_SLEEP_WAIT;
          default: state_next = ST_IDLE;
        endcase
      end
      ST_READ: state_next = ST_WRITE;
      ST_WRITE: begin
        if (op_reg == OP_PROGRAM || idx_reg == PAGE_LAST) begin
          state_next = ST_DONE;
        end else begin
          idx_next = idx_reg + 5'h01;
          state_next = ST_READ;
        end
      end
      ST_SLEEP_WAIT: begin
        // zero threshold can never be undercut, so it means sleep at once
        if (wake_thr == 3'b000 || level_s < wake_thr) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wire_edge) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_ERASE;
      idx_reg <= 5'h00;
      page_reg <= 2'b00;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      idx_reg <= idx_next;
      page_reg <= page_next;
    end
  end

  // storage port: sequencer owns it while busy, otherwise host reads flash
  logic seq_busy;
  logic in_write;
  assign seq_busy = (state_reg == ST_READ) || (state_reg == ST_WRITE);
  assign in_write = state_reg == ST_WRITE;

  always_comb begin
    mem_bus.fl_addr = reg_addr_i;
    mem_bus.ram_addr = idx_reg;
    mem_bus.fl_we = 1'b0;
    mem_bus.ram_we = 1'b0;
    mem_bus.fl_wdata = ERASED_BYTE;
    mem_bus.ram_wdata = mem_bus.fl_rdata;
    if (seq_busy) begin
      mem_bus.fl_addr = (op_reg == OP_PROGRAM) ? prog_addr_reg[6:0] : {page_reg, idx_reg};
      unique case (op_reg)
        OP_ERASE: begin
          mem_bus.fl_we = in_write;
          mem_bus.fl_wdata = ERASED_BYTE;
        end
        OP_PROGRAM: begin
          // addresses with bit 7 set are dropped here, the rest past the array by the storage
          mem_bus.fl_we = in_write && !prog_addr_reg[7];
          mem_bus.fl_wdata = mem_bus.fl_rdata & prog_data_reg;
        end
        OP_RAM_TO_FLASH: begin
          // programming only clears bits, so erase page 0 first for a true copy
          mem_bus.fl_we = in_write;
          mem_bus.fl_wdata = mem_bus.fl_rdata & mem_bus.ram_rdata;
        end
        OP_FLASH_TO_RAM: begin
          mem_bus.ram_we = in_write;
        end
      endcase
    end
  end

  // host read path: answer two cycles after the strobe
  logic rd_pend_reg, rd_pend_next;
  logic [6:0] rd_addr_reg, rd_addr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] mode_view;

  always_comb begin
    mode_view = mode_reg;
    mode_view[MODE_SLOW_CHG_BIT] = slow_flag[CH_CHARGE];
    mode_view[MODE_SLOW_DIS_BIT] = slow_flag[CH_DISCHARGE];
    if (mode_reg[MODE_DIR_BIT]) begin
      mode_view[MODE_LEVEL_BIT] = gpio_s;
    end
    rd_pend_next = reg_rd_i;
    rd_addr_next = reg_addr_i;
    rvalid_next = rd_pend_reg;
    rdata_next = rdata_reg;
    if (rd_pend_reg) begin
      if (rd_addr_reg < FLASH_BYTES) begin
        rdata_next = mem_bus.fl_rdata;
      end else begin
        unique case (rd_addr_reg)
          ADDR_FLASH_COMMAND: rdata_next = cmd_reg;
          ADDR_COUNTER_CLEAR: rdata_next = {3'b000, clear_reg};
          ADDR_MODE_CONTROL: rdata_next = mode_view;
          ADDR_CHARGE_TIME_LOW: rdata_next = time_cnt[CH_CHARGE][7:0];
          ADDR_CHARGE_TIME_HIGH: rdata_next = time_cnt[CH_CHARGE][15:8];
          ADDR_DISCHARGE_TIME_LOW: rdata_next = time_cnt[CH_DISCHARGE][7:0];
          ADDR_DISCHARGE_TIME_HIGH: rdata_next = time_cnt[CH_DISCHARGE][15:8];
          ADDR_PROGRAM_DATA: rdata_next = prog_data_reg;
          ADDR_PROGRAM_ADDRESS: rdata_next = prog_addr_reg;
          default: rdata_next = ZERO_BYTE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 7'h00;
      rdata_reg <= ZERO_BYTE;
      rvalid_reg <= 1'b0;
    end else begin
      rd_pend_reg <= rd_pend_next;
      rd_addr_reg <= rd_addr_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // open drain: only ever pulls low, enable is active low
  logic oe_n_reg, oe_n_next;
  always_comb begin
    oe_n_next = mode_reg[MODE_DIR_BIT] || mode_reg[MODE_LEVEL_BIT];
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= oe_n_next;
    end
  end

  assign gpio_out_o = 1'b0;
  assign gpio_oe_n_o = oe_n_reg;
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign sleep_o = state_reg == ST_SLEEP;
  assign busy_o = cmd_reg != ZERO_BYTE;
endmodule

// ===== design/gtm_top_note.sv
// no logic of its own: the block's top module is gtm_regs

// ===== tb/gtm_host.sv
// host controller model driving the register bus
`timescale 1ns/1ns
module gtm_host import gtm_pkg::*; (
  input wire logic sys_clk_i,
  output logic [REG_ADDR_W-1:0] reg_addr_o,
  output logic [DATA_W-1:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [DATA_W-1:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  initial begin
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  task automatic put(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= (a == ADDR_COUNTER_CLEAR) ? (d & 8'h1F) : d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
  endtask
  // a missing answer comes back unknown so the caller's compare fails
  task automatic get(input logic [6:0] a, output logic [7:0] d);
    int n;
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    for (n = 0; n < 6 && reg_rvalid_i !== 1'b1; n++) begin
      @(posedge sys_clk_i);
    end
    d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
  endtask
endmodule

// ===== tb/gtm_monitor.sv
// checker on the register block's ports
`timescale 1ns/1ns
module gtm_monitor import gtm_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_rvalid_o,
  input wire logic single_wire_pin_i,
  input wire logic gpio_oe_n_o,
  input wire logic [2:0] count_clear_o,
  input wire logic sleep_o,
  input wire logic busy_o
);
  logic clr_wr;
  logic cmd_wr;
  logic known;
  logic pin_reg;
  logic pin_next;
  logic [3:0] age_reg;
  logic [3:0] age_next;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  assign clr_wr = reg_wr_i && reg_addr_i == ADDR_COUNTER_CLEAR;
  assign cmd_wr = reg_wr_i && reg_addr_i == ADDR_FLASH_COMMAND && !busy_o && !sleep_o;
  assign known = reg_wdata_i inside {CMD_PROGRAM_BYTE, CMD_ERASE_PAGE0, CMD_ERASE_PAGE1,
    CMD_ERASE_PAGE2, CMD_RAM_TO_FLASH, CMD_FLASH_TO_RAM, CMD_POWER_DOWN};
  // cycles since the serial pin last moved, saturating
  always_comb begin
    pin_next = single_wire_pin_i;
    age_next = (single_wire_pin_i != pin_reg) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hF};
  end
  always_ff @(posedge sys_clk_i) begin
    pin_reg <= pin_next;
    age_reg <= rst_i ? 4'hF : age_next;
  end
  sequence s_read; reg_rd_i; endsequence
  sequence s_answer; ##2 reg_rvalid_o; endsequence
  property p_read_answer; s_read |-> s_answer; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_stray; reg_rvalid_o |-> $past(reg_rd_i, 2); endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without read");
  property p_reset_state;
    $fell(rst_i) |-> gpio_oe_n_o && !busy_o && !sleep_o && count_clear_o == 3'h0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");
  property p_clear_pulse; clr_wr && reg_wdata_i[0] |-> ##[1:3] count_clear_o[0]; endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("no clear pulse");
  property p_clear_cause;
    count_clear_o != 3'h0 |-> $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("stray clear");
  property p_cmd_start; cmd_wr && reg_wdata_i != 8'h00 |-> ##[1:2] busy_o; endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("command not started");
  property p_unknown; cmd_wr && !known |-> ##3 !busy_o && !sleep_o; endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code kept");
  property p_wake; sleep_o && $changed(single_wire_pin_i) |-> ##[1:6] !sleep_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake on pin edge");
  property p_sleep_hold; $fell(sleep_o) |-> age_reg < 4'h8; endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("woke without edge");
endmodule
bind gtm_regs gtm_monitor gtm_monitor_inst (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rvalid_o, .single_wire_pin_i, .gpio_oe_n_o, .count_clear_o,
  .sleep_o, .busy_o);

// ===== tb/gtm_regs_tb.sv
// self-checking bench for the time, mode, clear and flash command registers
`timescale 1ns/1ns
module gtm_regs_tb;
  import gtm_pkg::*;
  localparam longint FDIV = 1;
  localparam longint SDIV = 2;
  localparam int HOLD = 65580;
  localparam logic [15:0] SLOW_EXP = 16'((HOLD - 65536 * FDIV) / SDIV);
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic discharge_i = 1'b0;
  logic charge_i = 1'b0;
  logic supply_low_i = 1'b0;
  logic single_wire_pin_i = 1'b1;
  logic gpio_ext = 1'b1;
  logic [2:0] sense_level_i = 3'h0;
  logic gpio_in_i;
  logic gpio_out;
  logic gpio_oe_n;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic reg_rvalid;
  logic sleep;
  logic busy;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 32'h335a;
  // open drain: low while our driver is on, else the outside level
  assign gpio_in_i = gpio_oe_n ? gpio_ext : gpio_out;
  gtm_regs #(.FAST_DIV(FDIV), .SLOW_DIV(SDIV)) gtm_regs_inst (.sys_clk_i, .rst_i,
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .discharge_i, .charge_i,
    .sense_level_i, .supply_low_i, .single_wire_pin_i, .gpio_in_i, .gpio_out_o(gpio_out),
    .gpio_oe_n_o(gpio_oe_n), .count_clear_o(), .sleep_o(sleep), .busy_o(busy));
  gtm_host gtm_host_inst (.sys_clk_i, .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [7:0] mode_view(input logic [7:0] w, input logic slow_charge_flag, input logic por);
    mode_view = {w[7], w[7] ? gpio_ext : w[6], slow_charge_flag, 1'b0, w[3:1], por};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    gtm_host_inst.put(a, d);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    gtm_host_inst.get(a, d);
    check(16'(d), 16'(e));
  endtask
  task automatic acc(input logic [6:0] lo, output logic [15:0] v);
    logic [7:0] l;
    logic [7:0] h;
    gtm_host_inst.get(lo, l);
    gtm_host_inst.get(lo + 7'h01, h);
    v = {h, l};
  endtask
  task automatic cmd(input logic [7:0] c);
    int n;
    wr(ADDR_FLASH_COMMAND, c);
    repeat (3) @(posedge sys_clk_i);
    for (n = 0; n < 200 && busy !== 1'b0; n++) begin
      @(posedge sys_clk_i);
    end
    check(16'(busy), 16'h0000);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    tick(HOLD + 20000);
    mismatches++;
    end_of_test();
  end
  initial begin
    logic [7:0] d;
    logic [7:0] d2;
    logic [6:0] a;
    logic [15:0] v;
    int i;
    tick(12);
    rst_i <= 1'b0;
    tick(2);
    rdchk(ADDR_MODE_CONTROL, MODE_RESET);
    rdchk(ADDR_COUNTER_CLEAR, 8'h00);
    check(16'(gpio_oe_n), 16'h0001);
    wr(ADDR_MODE_CONTROL, 8'h00);
    tick(3);
    check(16'(gpio_oe_n), 16'h0000);
    rdchk(ADDR_MODE_CONTROL, 8'h00);
    wr(ADDR_MODE_CONTROL, 8'hBE);
    tick(3);
    check(16'(gpio_oe_n), 16'h0001);
    rdchk(ADDR_MODE_CONTROL, mode_view(8'hBE, 1'b0, 1'b0));
    supply_low_i <= 1'b1;
    tick(4);
    supply_low_i <= 1'b0;
    tick(4);
    rdchk(ADDR_MODE_CONTROL, mode_view(8'hBE, 1'b0, 1'b1));
    discharge_i <= 1'b1;
    tick(300);
    discharge_i <= 1'b0;
    tick(6);
    acc(ADDR_DISCHARGE_TIME_LOW, v);
    check(16'(v inside {[16'h012A:16'h012E]}), 16'h0001);
    wr(ADDR_CHARGE_TIME_LOW, 8'($random(seed)));
    acc(ADDR_CHARGE_TIME_LOW, v);
    check(v, 16'h0000);
    wr(ADDR_COUNTER_CLEAR, 8'h08);
    acc(ADDR_DISCHARGE_TIME_LOW, v);
    check(v, 16'h0000);
    for (i = 0; i < 5; i++) begin
      wr(ADDR_COUNTER_CLEAR, 8'h01 << i);
      rdchk(ADDR_COUNTER_CLEAR, 8'h00);
    end
    rdchk(7'h71 + 7'($random(seed) & 7), 8'h00);
    for (i = 0; i < 3; i++) begin
      a = 7'(i * 32) + 7'($random(seed) & 31);
      d = 8'($random(seed));
      d2 = 8'($random(seed));
      cmd(8'(CMD_ERASE_PAGE0 + i));
      rdchk(a, ERASED_BYTE);
      wr(ADDR_PROGRAM_ADDRESS, {1'b0, a});
      wr(ADDR_PROGRAM_DATA, d);
      cmd(CMD_PROGRAM_BYTE);
      rdchk(a, d);
      wr(ADDR_PROGRAM_DATA, d2);
      cmd(CMD_PROGRAM_BYTE);
      rdchk(a, d & d2);
      cmd(8'h33);
      rdchk(a, d & d2);
      cmd(8'(CMD_ERASE_PAGE0 + i));
      rdchk(a, ERASED_BYTE);
    end
    d = 8'($random(seed));
    wr(ADDR_PROGRAM_ADDRESS, 8'h03);
    wr(ADDR_PROGRAM_DATA, d);
    cmd(CMD_PROGRAM_BYTE);
    cmd(CMD_FLASH_TO_RAM);
    cmd(CMD_ERASE_PAGE0);
    rdchk(7'h03, ERASED_BYTE);
    cmd(CMD_RAM_TO_FLASH);
    rdchk(7'h03, d);
    rdchk(7'h1F, ERASED_BYTE);
    wr(ADDR_MODE_CONTROL, 8'h86);
    sense_level_i <= 3'h5;
    wr(ADDR_FLASH_COMMAND, CMD_POWER_DOWN);
    tick(20);
    check(16'(sleep), 16'h0000);
    sense_level_i <= 3'h2;
    tick(28);
    check(16'(sleep), 16'h0001);
    single_wire_pin_i <= 1'b0;
    tick(8);
    check(16'(sleep || busy), 16'h0000);
    wr(ADDR_MODE_CONTROL, 8'h80);
    sense_level_i <= 3'h7;
    wr(ADDR_FLASH_COMMAND, CMD_POWER_DOWN);
    tick(5);
    check(16'(sleep), 16'h0001);
    single_wire_pin_i <= 1'b1;
    tick(8);
    check(16'(sleep || busy), 16'h0000);
    wr(ADDR_COUNTER_CLEAR, 8'h10);
    charge_i <= 1'b1;
    tick(HOLD);
    charge_i <= 1'b0;
    tick(6);
    rdchk(ADDR_MODE_CONTROL, mode_view(8'h80, 1'b1, 1'b0));
    acc(ADDR_CHARGE_TIME_LOW, v);
    check(16'(v inside {[SLOW_EXP - 16'h3:SLOW_EXP + 16'h3]}), 16'h0001);
    wr(ADDR_COUNTER_CLEAR, 8'h10);
    rdchk(ADDR_MODE_CONTROL, mode_view(8'h80, 1'b0, 1'b0));
    end_of_test();
  end
endmodule
